//--- src/ldic_capture.v
// ddr input capture front end: lanes, frame marker, alarm, reference and current code
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "ldic_defines.vh"
// Function
// - latch sixteen lanes on both clock edges
// - default lane 15 msb, lane 0 lsb
// - reverse bit swaps lane significance
// - rising frame sample resets pointer or syncs
// - falling frame sample used as parity of the frame-start word
// - frame marker shows start of frame
// - alarm active low, high when polarity set
// - alarm sources chosen by alarm configuration register
// - coarse current code from bits 15:12
// - reference internal driven out unless external selected

module ldic_capture (
    input  wire        i_clock,                    // system clock, 200 mhz
    input  wire        i_rst_n,                    // async reset, active low
    input  wire        i_psel,                     // apb select
    input  wire        i_penable,                  // apb access phase
    input  wire        i_pwrite,                   // apb direction
    input  wire [11:0] i_paddr,                    // apb byte address
    input  wire [31:0] i_pwdata,                   // apb write data
    output wire [31:0] o_prdata,                   // apb read data
    output wire        o_pready,                   // apb ready
    output wire        o_pslverr,                  // apb error
    input  wire        i_forwarded_clock_positive, // forwarded data clock from source
    input  wire [15:0] i_data_lanes,               // ddr data lanes
    input  wire        i_frame_marker_positive,    // frame marker
    input  wire        i_converter_ready,          // converter side pulls a sample
    output reg  [15:0] o_sample,                   // sample handed to converter side
    output reg         o_sample_valid,             // sample strobe, one cycle
    output wire        o_alarm,                    // alarm pin, polarity selectable
    output wire        o_irq,                      // level interrupt
    output reg  [3:0]  o_coarse_current,           // full-scale current code
    output wire        o_reference_pin_out,        // reference drive value
    output wire        o_reference_pin_oe_n,       // low while internal reference drives pin
    output wire        o_frame_start               // start-of-frame pulse
);

    // ----------
    // declarations
    // ----------
    wire [15:0] general;     // general configuration
    wire [15:0] busfmt;      // bus format configuration
    wire [15:0] outcfg;      // output configuration
    wire [15:0] alarmsrc;    // alarm source selection
    wire [15:0] refcfg;      // reference configuration
    wire [4:0]  status;      // sticky status
    wire [4:0]  mask;        // interrupt mask
    wire        clk_s;       // synchronised forwarded clock
    wire        frame_s;     // synchronised frame marker
    wire [15:0] lanes_s;     // synchronised lanes
    reg         clk_d_r;     // previous forwarded clock level
    reg  [15:0] word_r;      // captured word, significance applied
    reg         word_v_r;    // captured word valid
    reg         frame_r_r;   // frame marker at last rising edge
    reg         frame_f_r;   // frame marker at last falling edge
    reg         frame_rise_r;// previous rising-edge frame sample
    reg  [4:0]  events_r;    // event pulses to status
    reg  [15:0] mem_r [0:`LDIC_FIFO_DEPTH-1]; // sample fifo
    reg  [2:0]  wptr_r;      // write pointer
    reg  [2:0]  rptr_r;      // read pointer
    reg  [3:0]  fill_r;      // fill level
    reg  [15:0] capcnt_r;    // captured word count
    reg         parity_acc_r;// running xor of block
    reg  [3:0]  fill_nxt;    // next fill level
    reg  [15:0] ordered;     // lanes in chosen significance
    integer     k;           // bit loop index
    // combinational helpers
    wire        rise;        // forwarded clock rising
    wire        fall;        // forwarded clock falling
    wire        do_wr;       // fifo write
    wire        do_rd;       // fifo read
    wire        frame_start; // frame begins this rising edge
    wire        alarm_act;   // any enabled alarm source
    wire        ptr_reset;   // frame resets pointers

    // ----------
    // register file
    // ----------
    // status feeds alarm and irq; mask feeds irq only
    ldic_apb_regs u_regs (
        .i_clock    (i_clock),
        .i_rst_n    (i_rst_n),
        .i_psel     (i_psel),
        .i_penable  (i_penable),
        .i_pwrite   (i_pwrite),
        .i_paddr    (i_paddr),
        .i_pwdata   (i_pwdata),
        .o_prdata   (o_prdata),
        .o_pready   (o_pready),
        .o_pslverr  (o_pslverr),
        .i_events   (events_r),
        .i_sample   (word_r),
        .i_capcnt   (capcnt_r),
        .o_general  (general),
        .o_busfmt   (busfmt),
        .o_output   (outcfg),
        .o_alarmsrc (alarmsrc),
        .o_refcfg   (refcfg),
        .o_status   (status),
        .o_mask     (mask)
    );

    // ----------
    // pin synchronisers: clock, frame and lanes share delay so they stay aligned
    // ----------
    // no logic reads a pin before two flops
    ldic_sync2 u_sclk (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async (i_forwarded_clock_positive),
        .o_sync  (clk_s)
    );

    ldic_sync2 u_sfrm (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async (i_frame_marker_positive),
        .o_sync  (frame_s)
    );

    // one synchroniser per lane
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_lane
            ldic_sync2 u_slane (
                .i_clock (i_clock),
                .i_rst_n (i_rst_n),
                .i_async (i_data_lanes[g]),
                .o_sync  (lanes_s[g])
            );
        end
    endgenerate

    // ----------
    // edge detect on the synchronised forwarded clock
    // ----------
    // last level of the synchronised clock
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clk_d_r <= 1'b0;
        end else begin
            clk_d_r <= clk_s;
        end
    end

    // limitation: the forwarded clock must run well below a quarter of i_clock
    assign rise = clk_s & ~clk_d_r;
    assign fall = ~clk_s & clk_d_r;

    // ----------
    // lane significance
    // ----------
    // the reverse bit flips all lanes at once
    always @* begin
        ordered = lanes_s;  // lane 15 msb by default
        if (busfmt[`LDIC_BUS_REVBUS]) begin
            for (k = 0; k < 16; k = k + 1) begin
                ordered[k] = lanes_s[15-k];  // lowest lane becomes msb
            end
        end
    end

    // frame marker rises at this rising clock edge
    assign frame_start = rise & frame_s & ~frame_rise_r;

    // pointer reset use only when not configured as a sync source
    assign ptr_reset   = frame_start & ~busfmt[`LDIC_BUS_FRAME_SYNC];
    assign o_frame_start = frame_start;

    // ----------
    // word and frame capture on both edges
    // ----------
    // events leave as one-cycle pulses
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word_r       <= 16'h0000;
            word_v_r     <= 1'b0;
            frame_r_r    <= 1'b0;
            frame_f_r    <= 1'b0;
            frame_rise_r <= 1'b0;
            parity_acc_r <= 1'b0;
            capcnt_r     <= 16'h0000;
            events_r     <= 5'h00;
        end else begin
            word_v_r <= rise | fall;
            events_r <= 5'h00;
            if (rise | fall) begin
                word_r   <= ordered;  // both edges latch a word
                capcnt_r <= capcnt_r + 16'h0001;
            end
            if (rise) begin
                frame_r_r    <= frame_s;  // rising sample of marker
                frame_rise_r <= frame_s;
                if (frame_start) begin
                    events_r[`LDIC_EV_FRAME] <= 1'b1;
                    events_r[`LDIC_EV_SYNC]  <= busfmt[`LDIC_BUS_FRAME_SYNC];  // sync source use
                end
            end

            if (fall) begin
                frame_f_r <= frame_s;  // falling sample is the parity bit of the frame-start word
                // running xor restarts at frame start; parity bit compared with the xor of the frame-start word only
                if (busfmt[`LDIC_BUS_PAR_ENA] && frame_rise_r &&
                    ((parity_acc_r ^ busfmt[`LDIC_BUS_PAR_ODD]) != frame_s)) begin
                    events_r[`LDIC_EV_PARITY] <= 1'b1;
                end
            end
            if (frame_start) begin
                parity_acc_r <= ^ordered;
            end else if (rise | fall) begin
                parity_acc_r <= parity_acc_r ^ (^ordered);
            end
            // a word meeting a full fifo is lost
            if (word_v_r && fill_r == `LDIC_FIFO_DEPTH && !do_rd) begin
                events_r[`LDIC_EV_OVERRUN] <= 1'b1;
            end
        end
    end

    // ----------
    // sample fifo between capture and converter side
    // ----------
    // a full fifo refuses rather than overwrites
    assign do_wr = word_v_r & (fill_r != `LDIC_FIFO_DEPTH);
    assign do_rd = i_converter_ready & (fill_r != 4'h0);

    // push with pop keeps the level
    always @* begin
        fill_nxt = fill_r;
        if (do_wr && !do_rd) begin
            fill_nxt = fill_r + 4'h1;
        end else if (do_rd && !do_wr) begin
            fill_nxt = fill_r - 4'h1;
        end
    end

    // flops only; pointer reset on frame realigns the read side
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wptr_r         <= 3'h0;
            rptr_r         <= 3'h0;
            fill_r         <= 4'h0;
            o_sample       <= 16'h0000;
            o_sample_valid <= 1'b0;
        end else begin
            o_sample_valid <= do_rd;
            if (do_rd) begin
                o_sample <= mem_r[rptr_r];
            end
            // words still held are dropped
            if (ptr_reset) begin
                wptr_r <= 3'h0;  // frame resets fifo pointer
                rptr_r <= 3'h0;
                fill_r <= 4'h0;
            end else begin
                if (do_wr) begin
                    wptr_r <= wptr_r + 3'h1;
                end
                if (do_rd) begin
                    rptr_r <= rptr_r + 3'h1;
                end
                fill_r <= fill_nxt;
            end
        end
    end

    // fifo storage, no reset needed on data
    always @(posedge i_clock) begin
        if (do_wr && !ptr_reset) begin
            mem_r[wptr_r] <= word_r;
        end
    end

    // ----------
    // alarm, interrupt, current code and reference
    // ----------
    // alarm ignores the interrupt mask
    assign alarm_act = |(status & alarmsrc[4:0]);  // sources picked by alarm register
    assign o_alarm   = general[`LDIC_GEN_ALARM_POL] ? alarm_act : ~alarm_act;

    // irq: any unmasked sticky status bit
    assign o_irq     = |(status & mask);

    // registered so the code never glitches
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_coarse_current <= 4'hf;
        end else begin
            o_coarse_current <= outcfg[`LDIC_OUT_COARSE_HI:`LDIC_OUT_COARSE_LO];
        end
    end

    // bit 0 clear drives internal reference out; bit 0 set releases pin for external
    assign o_reference_pin_out  = ~refcfg[`LDIC_REF_EXTREF];
    assign o_reference_pin_oe_n = refcfg[`LDIC_REF_EXTREF];

    wire unused_ok = frame_r_r | frame_f_r;
endmodule

//--- inc/ldic_defines.vh
// register offsets, field positions, reset values and fifo depth for the ddr input capture block
`ifndef LDIC_DEFINES_VH
`define LDIC_DEFINES_VH
// ----------
// apb register byte offsets
// ----------
`define LDIC_ADDR_GENERAL   12'h000
`define LDIC_ADDR_BUSFMT    12'h008
`define LDIC_ADDR_OUTPUT    12'h00c
`define LDIC_ADDR_ALARMSRC  12'h01c
`define LDIC_ADDR_REFCFG    12'h06c
`define LDIC_ADDR_STATUS    12'h080
`define LDIC_ADDR_IRQMASK   12'h084
`define LDIC_ADDR_SAMPLE    12'h088
`define LDIC_ADDR_CAPCNT    12'h08c
// ----------
// field positions
// ----------
`define LDIC_GEN_ALARM_POL  0
`define LDIC_BUS_REVBUS     0
`define LDIC_BUS_FRAME_SYNC 1
`define LDIC_BUS_PAR_ENA    2
`define LDIC_BUS_PAR_ODD    3
`define LDIC_OUT_COARSE_HI  15
`define LDIC_OUT_COARSE_LO  12
`define LDIC_REF_EXTREF     0
// status / mask / alarm source bits
`define LDIC_EV_FRAME       0
`define LDIC_EV_SYNC        1
`define LDIC_EV_PARITY      2
`define LDIC_EV_OVERRUN     3
`define LDIC_EV_W           4
// ----------
// reset values and fifo depth
// ----------
`define LDIC_RST_GENERAL    16'h0000
`define LDIC_RST_BUSFMT     16'h0000
`define LDIC_RST_OUTPUT     16'hf000
`define LDIC_RST_ALARMSRC   16'h0000
`define LDIC_RST_REFCFG     16'h0000
`define LDIC_FIFO_DEPTH     8
`endif

//--- src/ldic_sync2.v
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module ldic_sync2 (
    input  wire i_clock,  // sampling clock
    input  wire i_rst_n,  // async reset, active low
    input  wire i_async,  // level from another domain
    output wire o_sync    // synchronised level
);
    reg meta_r;  // first stage, read only by the second
    reg sync_r;  // second stage
    // ----------------------------------------------------------------
    // two stages
    // ----------------------------------------------------------------
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end
    assign o_sync = sync_r;
endmodule

//--- src/ldic_apb_regs.v
// apb slave holding configuration, sticky status and mask registers
`timescale 1ns/1ps
`include "ldic_defines.vh"
module ldic_apb_regs (
    input  wire        i_clock,     // system clock
    input  wire        i_rst_n,     // async reset, active low
    input  wire        i_psel,      // apb select
    input  wire        i_penable,   // apb access phase
    input  wire        i_pwrite,    // apb direction
    input  wire [11:0] i_paddr,     // apb byte address
    input  wire [31:0] i_pwdata,    // apb write data
    output reg  [31:0] o_prdata,    // apb read data
    output wire        o_pready,    // apb ready, always one cycle access
    output wire        o_pslverr,   // apb error for unmapped address
    input  wire [4:0]  i_events,    // one-cycle event pulses
    input  wire [15:0] i_sample,    // last captured sample
    input  wire [15:0] i_capcnt,    // captured word count
    output reg  [15:0] o_general,   // general configuration
    output reg  [15:0] o_busfmt,    // bus format configuration
    output reg  [15:0] o_output,    // output configuration
    output reg  [15:0] o_alarmsrc,  // alarm source selection
    output reg  [15:0] o_refcfg,    // reference configuration
    output reg  [4:0]  o_status,    // sticky event status
    output wire [4:0]  o_mask       // interrupt mask
);
    reg  [4:0] mask_r;   // interrupt mask
    wire       wr_en;    // write takes effect this edge
    reg        hit;      // address decodes
    reg [31:0] rd_mux;   // read data before register
    assign wr_en     = i_psel & i_penable & i_pwrite;
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~hit;
    // ----------
    // read decode
    // ----------
    always @* begin
        hit    = 1'b1;
        rd_mux = 32'h00000000;
        case (i_paddr)
            `LDIC_ADDR_GENERAL:  rd_mux = {16'h0000, o_general};
            `LDIC_ADDR_BUSFMT:   rd_mux = {16'h0000, o_busfmt};
            `LDIC_ADDR_OUTPUT:   rd_mux = {16'h0000, o_output};
            `LDIC_ADDR_ALARMSRC: rd_mux = {16'h0000, o_alarmsrc};
            `LDIC_ADDR_REFCFG:   rd_mux = {16'h0000, o_refcfg};
            `LDIC_ADDR_STATUS:   rd_mux = {27'h0000000, o_status};
            `LDIC_ADDR_IRQMASK:  rd_mux = {27'h0000000, mask_r};
            `LDIC_ADDR_SAMPLE:   rd_mux = {16'h0000, i_sample};
            `LDIC_ADDR_CAPCNT:   rd_mux = {16'h0000, i_capcnt};
            default:             hit = 1'b0;  // unmapped reads zero with slverr
        endcase
    end
    // ----------
    // registers; read data registered in setup so it is valid in access
    // ----------
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_general  <= `LDIC_RST_GENERAL;
            o_busfmt   <= `LDIC_RST_BUSFMT;
            o_output   <= `LDIC_RST_OUTPUT;
            o_alarmsrc <= `LDIC_RST_ALARMSRC;
            o_refcfg   <= `LDIC_RST_REFCFG;
            mask_r     <= 5'h00;
            o_status   <= 5'h00;
            o_prdata   <= 32'h00000000;
        end else begin
            if (i_psel && !i_penable) begin
                o_prdata <= rd_mux;
            end
            if (wr_en && i_paddr == `LDIC_ADDR_GENERAL)  o_general  <= i_pwdata[15:0];
            if (wr_en && i_paddr == `LDIC_ADDR_BUSFMT)   o_busfmt   <= i_pwdata[15:0];
            if (wr_en && i_paddr == `LDIC_ADDR_OUTPUT)   o_output   <= i_pwdata[15:0];
            if (wr_en && i_paddr == `LDIC_ADDR_ALARMSRC) o_alarmsrc <= i_pwdata[15:0];
            if (wr_en && i_paddr == `LDIC_ADDR_REFCFG)   o_refcfg   <= i_pwdata[15:0];
            if (wr_en && i_paddr == `LDIC_ADDR_IRQMASK)  mask_r     <= i_pwdata[4:0];
            // a new event wins over a write-one clear in the same cycle
            if (wr_en && i_paddr == `LDIC_ADDR_STATUS) begin
                o_status <= (o_status & ~i_pwdata[4:0]) | i_events;
            end else begin
                o_status <= o_status | i_events;
            end
        end
    end
    assign o_mask = mask_r;  // gates the interrupt
endmodule

//--- tb/ldic_capture_checker.sv
// concurrent checks on the capture block ports
`timescale 1ns/1ps
module ldic_capture_checker (
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_forwarded_clock_positive,
    input wire logic        i_converter_ready,
    input wire logic        o_sample_valid,
    input wire logic        o_irq,
    input wire logic [3:0]  o_coarse_current,
    input wire logic        o_reference_pin_oe_n,
    input wire logic        o_frame_start
);
    // ----------
    // helper logic
    // ----------
    wire       acc    = i_psel && i_penable;        // apb access phase
    wire       wr     = acc && i_pwrite;            // write taking effect
    wire       wr_out = wr && i_paddr == 12'h00c;   // output config write
    wire       wr_ref = wr && i_paddr == 12'h06c;   // reference config write
    logic [3:0] cw_r;                               // last coarse code written
    logic       ref_r;                              // last reference select written
    logic       fclk_q;                             // previous pin level
    logic [3:0] age_r;                              // cycles since a pin edge
    // age saturates so it never wraps back into range
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cw_r   <= 4'hf;
            ref_r  <= 1'b0;
            fclk_q <= 1'b0;
            age_r  <= 4'hf;
        end else begin
            cw_r   <= wr_out ? i_pwdata[15:12] : cw_r;
            ref_r  <= wr_ref ? i_pwdata[0] : ref_r;
            fclk_q <= i_forwarded_clock_positive;
            age_r  <= (i_forwarded_clock_positive != fclk_q) ? 4'h0 : ((age_r == 4'hf) ? age_r : age_r + 4'h1);
        end
    end
    // ----------
    // assertions
    // ----------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    chk_ready_high: assert property (o_pready) else $error("pready low");
    chk_err_unmapped: assert property ((acc && !i_pwrite && i_paddr[11:8] != 4'h0) |-> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped read not refused");
    chk_err_only_access: assert property (o_pslverr |-> acc) else $error("slverr outside access");
    chk_rdata_stands: assert property (acc ##1 !(i_psel && !i_penable) |-> $stable(o_prdata))
        else $error("read data moved");
    chk_coarse_load: assert property (wr_out |-> ##[1:2] o_coarse_current == cw_r)
        else $error("coarse code not loaded");
    chk_coarse_hold: assert property ($changed(o_coarse_current) |-> $past(wr_out) || $past(wr_out, 2))
        else $error("coarse code moved alone");
    chk_ref_drive: assert property (wr_ref |-> ##[1:2] o_reference_pin_oe_n == ref_r)
        else $error("reference drive wrong");
    chk_irq_fall: assert property ($fell(o_irq) |-> $past(wr) || $past(wr, 2))
        else $error("irq fell without write");
    chk_frame_pulse: assert property (o_frame_start |=> !o_frame_start)
        else $error("frame start too long");
    chk_frame_edge: assert property (o_frame_start |-> age_r <= 4'd8)
        else $error("frame start without clock edge");
    chk_valid_ready: assert property (o_sample_valid |-> $past(i_converter_ready))
        else $error("sample without ready");
    cover property (o_frame_start);
    cover property (o_irq);
    cover property (o_pslverr);
endmodule
bind ldic_capture ldic_capture_checker u_chk (.*);

//--- tb/ldic_src_model.sv
// sample source driving the ddr lanes, forwarded clock and frame marker
`timescale 1ns/1ps
module ldic_src_model (
    output logic        o_clk,
    output logic [15:0] o_lanes,
    output logic        o_frame
);
    // clock stands still outside frames
    initial begin
        o_clk   = 1'b0;
        o_lanes = 16'h0;
        o_frame = 1'b0;
    end
    // one word per clock edge, data and marker edge aligned with the clock
    task automatic send(input logic [15:0] w[$]);
        #0.5;  // keeps pin edges off the sampling edges
        for (int i = 0; i < w.size(); i++) begin
            o_lanes = w[i];
            o_frame = (i == 0);             // marker high at first rising edge; parity slot low
            o_clk   = ~o_clk;
            #24;
        end
        o_lanes = ~o_lanes;                 // lanes carry no valid word between frames
        o_frame = 1'b0;
    endtask
endmodule

//--- tb/ldic_capture_tb.sv
// self-checking bench for the ddr input capture block
`timescale 1ns/1ps
`include "ldic_defines.vh"
module ldic_capture_tb;
    logic i_clock = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ready = 1, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, c, seed = 32'h20c01436;
    wire [31:0] prdata;
    wire pready, pslverr, fclk, frame, sval, alarm, irq, ref_out, ref_oe_n, fstart;
    wire [15:0] lanes, sample;
    wire [3:0] coarse;
    int fail_count = 0, num_checks = 0, nfs = 0, k;
    logic [15:0] got[$], sent[$];
    logic [11:0] ra[5] = '{`LDIC_ADDR_GENERAL, `LDIC_ADDR_BUSFMT, `LDIC_ADDR_OUTPUT, `LDIC_ADDR_ALARMSRC, `LDIC_ADDR_REFCFG};
    logic [15:0] rr[5] = '{`LDIC_RST_GENERAL, `LDIC_RST_BUSFMT, `LDIC_RST_OUTPUT, `LDIC_RST_ALARMSRC, `LDIC_RST_REFCFG};
    always #2.5 i_clock = ~i_clock;
    ldic_capture i_dut (.i_clock(i_clock), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_forwarded_clock_positive(fclk), .i_data_lanes(lanes), .i_frame_marker_positive(frame),
        .i_converter_ready(ready), .o_sample(sample), .o_sample_valid(sval), .o_alarm(alarm), .o_irq(irq),
        .o_coarse_current(coarse), .o_reference_pin_out(ref_out), .o_reference_pin_oe_n(ref_oe_n),
        .o_frame_start(fstart));
    ldic_src_model u_src (.o_clk(fclk), .o_lanes(lanes), .o_frame(frame));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected word for a given lane order
    function logic [15:0] exp_w(input logic [15:0] w, input logic rev);
        for (int b = 0; b < 16; b++) exp_w[b] = rev ? w[15-b] : w[b];
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] e, input string m);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    // one apb transfer; an idle edge first keeps back-to-back calls clean
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clock);
        psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge i_clock);
        pen <= 1;
        do @(posedge i_clock); while (pready !== 1'b1);  // only the watchdog ends a hang
        rd = prdata; err = pslverr;
        psel <= 0; pen <= 0;
    endtask
    task frame_run(input int cnt);
        sent.delete(); got.delete();
        for (int i = 0; i < cnt; i++) sent.push_back(16'(rnd()));
        u_src.send(sent);
    endtask
    task wait_got(input int n);
        for (int i = 0; i < 80 && got.size() < n; i++) @(posedge i_clock);
        repeat (4) @(posedge i_clock);
    endtask
    task settle; repeat (3) @(posedge i_clock); endtask
    always @(posedge i_clock) begin
        if (sval === 1'b1) got.push_back(sample);
        if (fstart === 1'b1) nfs++;
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog: the whole run needs well under this span
    initial begin
        #200000;
        fail_count++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge i_clock);
        rst_n <= 1;
        foreach (ra[i]) begin
            apb(0, ra[i], 0);
            chk(rd, {16'h0, rr[i]}, "reset value");
        end
        apb(0, 12'h200, 0);
        chk(err, 1'b1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        chk(coarse, 4'hf, "coarse reset");
        chk({ref_oe_n, ref_out}, 2'b01, "internal reference drives");
        $display("test registers done");
        // both lane orders; second pass also uses the marker as sync
        for (int rv = 0; rv < 2; rv++) begin
            apb(1, `LDIC_ADDR_BUSFMT, rv * 3);
            k = nfs;
            frame_run(6);
            wait_got(6);
            chk(got.size(), 6, "word count");
            foreach (sent[i]) chk(got[i], exp_w(sent[i], rv[0]), "lane order");
            chk(nfs - k, 1, "frame start count");
            apb(0, `LDIC_ADDR_STATUS, 0);
            chk(rd[rv], 1'b1, "frame or sync event");
            apb(1, `LDIC_ADDR_STATUS, 32'hf);
            $display("test capture order %0d done", rv);
        end
        // stall the converter side until the fifo refuses
        apb(1, `LDIC_ADDR_BUSFMT, 0);
        ready <= 0;
        frame_run(10);
        apb(0, `LDIC_ADDR_STATUS, 0);
        chk(rd[`LDIC_EV_OVERRUN], 1'b1, "overrun flagged");
        ready <= 1;
        wait_got(`LDIC_FIFO_DEPTH);
        chk(got.size(), `LDIC_FIFO_DEPTH, "fifo depth");
        for (int i = 0; i < `LDIC_FIFO_DEPTH; i++) chk(got[i], sent[i], "drained word");
        $display("test overrun done");
        // overrun still pending: raise, flip polarity, mask, clear
        apb(1, `LDIC_ADDR_ALARMSRC, 8); apb(1, `LDIC_ADDR_IRQMASK, 8); settle;
        chk(irq, 1'b1, "irq raised");
        chk(alarm, 1'b0, "alarm active low");
        apb(1, `LDIC_ADDR_GENERAL, 1); settle;
        chk(alarm, 1'b1, "alarm active high");
        apb(1, `LDIC_ADDR_IRQMASK, 0); settle;
        chk(irq, 1'b0, "irq masked");
        chk(alarm, 1'b1, "alarm kept");
        apb(1, `LDIC_ADDR_ALARMSRC, 0); settle;
        chk(alarm, 1'b0, "alarm source off");
        apb(1, `LDIC_ADDR_ALARMSRC, 8); apb(1, `LDIC_ADDR_IRQMASK, 8); apb(1, `LDIC_ADDR_STATUS, 8); settle;
        chk(irq, 1'b0, "irq cleared");
        $display("test alarm done");
        repeat (4) begin
            c = rnd();
            apb(1, `LDIC_ADDR_OUTPUT, {16'h0, c[3:0], 12'h0}); settle;
            chk(coarse, c[3:0], "coarse code");
        end
        apb(1, `LDIC_ADDR_REFCFG, 1); settle;
        chk({ref_oe_n, ref_out}, 2'b10, "external reference");
        apb(1, `LDIC_ADDR_REFCFG, 0); settle;
        chk({ref_oe_n, ref_out}, 2'b01, "internal reference");
        $display("test current and reference done");
        tally_and_finish;
    end
endmodule
